// [src/scd_pkg.sv]
// Constants, types and helpers shared by the SPI diagnostics monitor.
package scd_pkg;

	////////////////////////////////////////////////////////////////////////
	// SPI frame layout: command byte, data byte, checksum byte.
	localparam int         POS_W      = 5;
	localparam logic [4:0] POS_FIRST  = 5'h00;
	localparam logic [4:0] POS_DATA   = 5'h08;
	localparam logic [4:0] POS_CRC    = 5'h10;
	localparam logic [4:0] POS_LAST   = 5'h17;
	localparam int         CMD_RD_BIT = 7;
	localparam logic [7:0] CRC_POLY   = 8'h07;
	localparam logic [7:0] CRC_SEED   = 8'ha5;

	////////////////////////////////////////////////////////////////////////
	// Register addresses reachable over the serial port.
	localparam logic [6:0] ADDR_DEV_CFG   = 7'h02;
	localparam logic [6:0] ADDR_DEV_CFG1  = 7'h10;
	localparam logic [6:0] ADDR_DEV_STAT  = 7'h15;
	localparam logic [6:0] ADDR_DIAG      = 7'h25;
	localparam logic [6:0] ADDR_ERR_STAT  = 7'h40;
	localparam logic [6:0] ADDR_OVR       = 7'h41;
	localparam logic [6:0] ADDR_MCLK_CNT  = 7'h42;

	////////////////////////////////////////////////////////////////////////
	// Field positions and masks.
	localparam int         NO_CHIP_ERR_BIT = 4;
	localparam int         SRC_SEL_BIT     = 2;
	localparam int         FUSE_ECC_BIT    = 1;
	localparam int         DIAG_OVR_EN     = 5;
	localparam int         DIAG_MCLK_EN    = 3;
	localparam int         DIAG_CRC_EN     = 2;
	localparam int         DIAG_FUSE_GO    = 0;
	localparam logic [7:0] DIAG_WR_MASK    = 8'h2d;
	localparam int         ERR_FUSE        = 0;
	localparam int         ERR_RD          = 1;
	localparam int         ERR_WR          = 2;
	localparam int         ERR_SCLK        = 3;
	localparam int         ERR_CRC         = 4;
	localparam int         ERR_W           = 5;

	////////////////////////////////////////////////////////////////////////
	// Counters and sizes.
	localparam int         MCLK_DIV_CYCLES = 12000;
	localparam int         MCLK_CNT_W      = 8;
	localparam int         CHANNELS        = 4;
	localparam int         FUSE_WORDS_DEF  = 16;
	localparam logic [2:0] BIT_LAST        = 3'h7;

	typedef enum logic [1:0] {
		FS_IDLE   = 2'b00,
		FS_READ   = 2'b01,
		FS_SEARCH = 2'b10
	} scd_fuse_e;

	// True for an address that answers a read.
	function automatic logic scd_readable(input logic [6:0] a);
		return (a == ADDR_DEV_CFG) || (a == ADDR_DEV_CFG1) ||
			(a == ADDR_DEV_STAT) || (a == ADDR_DIAG) ||
			(a == ADDR_ERR_STAT) || (a == ADDR_OVR) ||
			(a == ADDR_MCLK_CNT);
	endfunction

	// True for an address that accepts a write.
	function automatic logic scd_writable(input logic [6:0] a);
		return (a == ADDR_DIAG) || (a == ADDR_DEV_CFG1);
	endfunction

	// Converts a three-bit gray count back to binary.
	function automatic logic [2:0] scd_gray2bin(input logic [2:0] g);
		return {g[2], g[2] ^ g[1], g[2] ^ g[1] ^ g[0]};
	endfunction

endpackage

// [src/scd_crc8_step.sv]
// One bit step of the eight-bit checksum shift register.
`timescale 1ns/1ps
module scd_crc8_step (
	input  wire logic [7:0] crc_in,  // Checksum before the bit.
	input  wire logic       bit_in,  // Message bit, first bit first.
	output logic      [7:0] crc_out  // Checksum after the bit.
);
	import scd_pkg::*;

	// Shift left and fold in the generator when the feedback bit is set.
	always_comb begin
		crc_out = {crc_in[6:0], 1'b0} ^
			((crc_in[7] ^ bit_in) ? CRC_POLY : 8'h00);
	end
endmodule // scd_crc8_step

// [src/scd_monitor.sv]
// SPI checksum, error status and self check logic of the converter.
//
// Summary of operation
// R1: Boot in minimum I/O, leave on select toggle.
// R2: Minimum I/O forces checksum; frames are 24 bits.
// R3: Source select copies conversion output onto SDO.
// R4: Host ties select, loops clock, sets formats.
// R5: Error flags clear on read, except master.
// R6: Master no-error bit low while any flag.
// R7: Power-up fuse read, checksum compare, flag mismatch.
// R8: Trigger bit starts check, self clears, suspends.
// R9: Single-bit fuse error corrected or flagged.
// R10: Enabled overrange sets read-clear channel flags.
// R11: Counter increments every 12000 clocks, wraps.
// R12: Undefined address ignored, read/write flag set.
// R13: Clock count not multiple of 8 flagged.
// R14: Enabled checksum checked; failure sets flag.
// R15: Checksum polynomial x8+x2+x+1, seed a5.
// R16: Checksum covers command and data on wire.
// R17: Host sends command, data, checksum bytes.
// R18: Device sends own checksum; writes only matching.
// R19: Write reply: status, fifteen zeros, checksum.
// R20: Read reply: status, seven zeros, data, checksum.
// R21: Status bit reports previous frame error.
// R22: Event during read-clear keeps its flag set.
`timescale 1ns/1ps
module scd_monitor #(
	parameter int MCLK_DIV   = scd_pkg::MCLK_DIV_CYCLES, // Clocks per tick.
	parameter int FUSE_WORDS = scd_pkg::FUSE_WORDS_DEF   // Fuse bytes.
) (
	input  wire logic                   clk,       // Master clock.
	input  wire logic                   rst,       // Async reset, high.
	input  wire logic                   sclk,      // Serial clock.
	input  wire logic                   cs_n,      // Chip select, low.
	input  wire logic                   sdi,       // Serial data in.
	input  wire logic                   conv_data, // Data path bit.
	output logic                        sdo,       // Register output pin.
	output logic                        first_conversion_output, // Data.
	output logic                        first_conversion_output_enable,
	output logic                        output_suspend,  // Check running.
	output logic [$clog2(FUSE_WORDS)-1:0] fuse_addr,   // Fuse index.
	input  wire logic [7:0]             fuse_data,       // Fuse byte.
	input  wire logic [7:0]             fuse_stored_crc, // Factory sum.
	input  wire logic [scd_pkg::CHANNELS-1:0] overrange_event, // Pulses.
	output logic [scd_pkg::CHANNELS-1:0] overrange_flags,  // Sticky.
	output logic [scd_pkg::ERR_W-1:0]   error_flags,     // Sticky.
	output logic                        no_chip_error,   // Master bit.
	output logic                        fuse_ecc_status, // Corrected.
	output logic [scd_pkg::MCLK_CNT_W-1:0] master_clock_counter, // Ticks.
	output logic                        minimum_io_mode  // Boot mode.
);
	import scd_pkg::*;

	localparam int FP_W = $clog2(FUSE_WORDS);
	localparam int FC_W = $clog2(FUSE_WORDS * 8);
	localparam int MD_W = $clog2(MCLK_DIV);

	////////////////////////////////////////////////////////////////////////
	// State of the master clock side.
	typedef struct packed {
		logic                  cs_meta;
		logic                  cs_sync;
		logic                  cs_prev;
		logic                  tgl_meta;
		logic                  tgl_sync;
		logic                  tgl_prev;
		logic                  done_d;
		logic [2:0]            cnt_meta;
		logic [2:0]            cnt_sync;
		logic [2:0]            cnt_last;
		logic                  min_io;
		logic                  src_sel;
		logic                  dout_en;
		logic [7:0]            diag;
		logic [ERR_W-1:0]      err;
		logic [CHANNELS-1:0]   ovr;
		logic                  ecc;
		logic                  no_err;
		logic [MD_W-1:0]       mdiv;
		logic [MCLK_CNT_W-1:0] mcnt;
		logic [ERR_W-1:0]      snap_err;
		logic [CHANNELS-1:0]   snap_ovr;
		logic                  snap_ecc;
		logic                  snap_noerr;
		logic [MCLK_CNT_W-1:0] snap_mcnt;
		scd_fuse_e             fs;
		logic [FP_W-1:0]       fptr;
		logic [2:0]            fbit;
		logic [7:0]            fcrc;
		logic [7:0]            fsynd;
		logic [7:0]            fwt;
		logic [FC_W-1:0]       fcnt;
		logic                  suspend;
	} scd_st_s;

	// State of the serial clock side.
	typedef struct packed {
		logic [2:0]  gray;
		logic [15:0] shift;
		logic [7:0]  cmd;
		logic [7:0]  crc;
		logic        crc_bad;
		logic [7:0]  f_cmd;
		logic [7:0]  f_data;
		logic        f_crc_ok;
		logic        tgl;
		logic        status;
		logic        sdo;
		logic        dout;
		logic        sel_meta;
		logic        sel_sync;
		logic        sus_meta;
		logic        sus_sync;
		logic        cen_meta;
		logic        cen_sync;
	} scd_lk_s;

	localparam scd_st_s ST_RST = '{min_io: 1'b1, no_err: 1'b1,
		snap_noerr: 1'b1, dout_en: 1'b1, fs: FS_READ, fcrc: CRC_SEED,
		default: '0};

	scd_st_s          st_reg;
	scd_st_s          st_next;
	scd_lk_s          lk_reg;
	scd_lk_s          lk_next;
	logic [4:0]       pos_reg;
	logic [4:0]       pos_next;
	logic             frame_rst;
	logic [7:0]       cur_cmd;
	logic             is_rd;
	logic [7:0]       rd_word;
	logic             tx;
	logic             crc_bit;
	logic             frame_ok;
	logic             conv_bit;
	logic [2:0]       gbin;
	logic [7:0]       spi_crc_in;
	logic [7:0]       spi_crc_step;
	logic [7:0]       fuse_crc_step;
	logic [7:0]       fuse_wt_step;
	logic             fuse_bit;
	logic             cs_rise;
	logic             cs_fall;
	logic             done;
	logic             f_rd;
	logic [6:0]       f_addr;
	logic             crc_en;
	logic             f_ok;
	logic [ERR_W-1:0] err_set;
	logic [ERR_W-1:0] err_clr;
	logic [CHANNELS-1:0] ovr_clr;
	logic             fuse_end;
	logic [7:0]       synd;

	////////////////////////////////////////////////////////////////////////
	// Bit position in the frame; select high restarts it, and in every mode
	// it wraps by itself after the last checksum bit.
	assign frame_rst = rst | cs_n;
	assign pos_next = (pos_reg == POS_LAST) ? POS_FIRST : pos_reg + 5'h01;

	always_ff @(posedge sclk or posedge frame_rst) begin
		if (frame_rst) begin
			pos_reg <= POS_FIRST;
		end else begin
			pos_reg <= pos_next; // R2
		end
	end

	// Checksum steps for the serial frame and for the fuse check.
	assign spi_crc_in = (pos_reg == POS_FIRST) ? CRC_SEED : lk_reg.crc;
	assign fuse_bit = fuse_data[3'(BIT_LAST - st_reg.fbit)];

	scd_crc8_step u_spi_crc (
		.crc_in  (spi_crc_in),
		.bit_in  (crc_bit),
		.crc_out (spi_crc_step)
	);

	scd_crc8_step u_fuse_crc (
		.crc_in  (st_reg.fcrc),
		.bit_in  (fuse_bit),
		.crc_out (fuse_crc_step)
	);

	scd_crc8_step u_fuse_wt (
		.crc_in  (st_reg.fwt),
		.bit_in  (1'b0),
		.crc_out (fuse_wt_step)
	);

	////////////////////////////////////////////////////////////////////////
	// Serial side: shifts the frame in, launches the reply on each rising
	// edge, and hands finished frames over with a toggle.
	always_comb begin
		lk_next = lk_reg;
		cur_cmd = (pos_reg == POS_DATA) ? lk_reg.shift[7:0] : lk_reg.cmd;
		is_rd = cur_cmd[CMD_RD_BIT];
		case (cur_cmd[6:0])
			ADDR_DEV_CFG:  rd_word = 8'(st_reg.snap_noerr) << NO_CHIP_ERR_BIT;
			ADDR_DEV_CFG1: rd_word = 8'(st_reg.src_sel) << SRC_SEL_BIT;
			ADDR_DEV_STAT: rd_word = 8'(st_reg.snap_ecc) << FUSE_ECC_BIT;
			ADDR_DIAG:     rd_word = st_reg.diag;
			ADDR_ERR_STAT: rd_word = 8'(st_reg.snap_err);
			ADDR_OVR:      rd_word = 8'(st_reg.snap_ovr);
			ADDR_MCLK_CNT: rd_word = 8'(st_reg.snap_mcnt);
			default:       rd_word = 8'h00;
		endcase
		// Status first, zeros, read data, then the own checksum.
		tx = 1'b0; // R19
		if (pos_reg == POS_FIRST) begin
			tx = lk_reg.status; // R21
		end else if (pos_reg >= POS_CRC) begin
			tx = lk_reg.crc[3'(POS_LAST - pos_reg)]; // R18
		end else if (pos_reg >= POS_DATA && is_rd) begin
			tx = rd_word[3'(POS_CRC - 5'h01 - pos_reg)]; // R20
		end
		// A read sums the data it sends, a write the data it receives.
		crc_bit = (pos_reg >= POS_DATA && is_rd) ? tx : sdi; // R16
		frame_ok = !(lk_reg.crc_bad || (sdi != tx));
		if (pos_reg < POS_CRC) begin
			lk_next.crc = spi_crc_step; // R15
			lk_next.shift = {lk_reg.shift[14:0], sdi};
		end else if (sdi != tx) begin
			lk_next.crc_bad = 1'b1; // R18
		end
		if (pos_reg == POS_FIRST) begin
			lk_next.crc_bad = 1'b0;
		end
		if (pos_reg == POS_DATA) begin
			lk_next.cmd = lk_reg.shift[7:0];
		end
		if (pos_reg == POS_LAST) begin
			lk_next.f_cmd = lk_reg.cmd;
			lk_next.f_data = lk_reg.shift[7:0];
			lk_next.f_crc_ok = frame_ok;
			lk_next.tgl = ~lk_reg.tgl;
			lk_next.status = (is_rd ? !scd_readable(lk_reg.cmd[6:0]) :
				!scd_writable(lk_reg.cmd[6:0])) ||
				(lk_reg.cen_sync && !frame_ok); // R21
		end
		// Gray count of every rising clock edge, read across on select rise.
		gbin = scd_gray2bin(lk_reg.gray) + 3'h1;
		lk_next.gray = gbin ^ (gbin >> 1); // R13
		lk_next.sel_meta = st_reg.src_sel;
		lk_next.sel_sync = lk_reg.sel_meta;
		lk_next.sus_meta = st_reg.suspend;
		lk_next.sus_sync = lk_reg.sus_meta;
		lk_next.cen_meta = st_reg.diag[DIAG_CRC_EN] | st_reg.min_io;
		lk_next.cen_sync = lk_reg.cen_meta;
		// Conversion data is held low while the fuse check runs.
		conv_bit = lk_reg.sus_sync ? 1'b0 : conv_data; // R8
		lk_next.dout = conv_bit;
		lk_next.sdo = lk_reg.sel_sync ? conv_bit : tx; // R3
	end

	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			lk_reg <= '0;
		end else begin
			lk_reg <= lk_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Master clock side: frame results, flags, fuse check and counter.
	always_comb begin
		st_next = st_reg;
		st_next.cs_meta = cs_n;
		st_next.cs_sync = st_reg.cs_meta;
		st_next.cs_prev = st_reg.cs_sync;
		st_next.tgl_meta = lk_reg.tgl;
		st_next.tgl_sync = st_reg.tgl_meta;
		st_next.tgl_prev = st_reg.tgl_sync;
		st_next.cnt_meta = lk_reg.gray;
		st_next.cnt_sync = st_reg.cnt_meta;
		cs_rise = st_reg.cs_sync & ~st_reg.cs_prev;
		cs_fall = ~st_reg.cs_sync & st_reg.cs_prev;
		done = st_reg.tgl_sync ^ st_reg.tgl_prev;
		st_next.done_d = done;
		f_rd = lk_reg.f_cmd[CMD_RD_BIT];
		f_addr = lk_reg.f_cmd[6:0];
		crc_en = st_reg.diag[DIAG_CRC_EN] | st_reg.min_io; // R2
		f_ok = !crc_en || lk_reg.f_crc_ok;
		err_set = '0;
		err_clr = '0;
		ovr_clr = '0;
		fuse_end = 1'b0;
		synd = fuse_crc_step ^ fuse_stored_crc;
		// Finished frame: check, then read-clear or write.
		if (done) begin
			if (crc_en && !lk_reg.f_crc_ok) begin
				err_set[ERR_CRC] = 1'b1; // R14
			end
			if (f_rd) begin
				if (!scd_readable(f_addr)) begin
					err_set[ERR_RD] = 1'b1; // R12
				end else if (f_ok && f_addr == ADDR_ERR_STAT) begin
					err_clr = st_reg.snap_err; // R5
				end else if (f_ok && f_addr == ADDR_OVR) begin
					ovr_clr = st_reg.snap_ovr; // R10
				end
			end else if (!scd_writable(f_addr)) begin
				err_set[ERR_WR] = 1'b1; // R12
			end else if (f_ok && f_addr == ADDR_DIAG) begin
				st_next.diag = (lk_reg.f_data & DIAG_WR_MASK) |
					(st_reg.diag & 8'h01); // R18
			end else if (f_ok) begin
				st_next.src_sel = lk_reg.f_data[SRC_SEL_BIT]; // R18
			end
		end
		// Select rise ends minimum I/O, or outside minimum I/O checks the edge count.
		if (cs_rise) begin
			st_next.min_io = 1'b0; // R1
			st_next.cnt_last = scd_gray2bin(st_reg.cnt_sync);
			if (!st_reg.min_io &&
				scd_gray2bin(st_reg.cnt_sync) != st_reg.cnt_last) begin
				err_set[ERR_SCLK] = 1'b1; // R13
			end
		end
		// Fuse check: checksum pass, then search for one flipped bit.
		case (st_reg.fs)
			FS_IDLE: begin
				if (st_reg.diag[DIAG_FUSE_GO]) begin
					st_next.fs = FS_READ; // R8
					st_next.fptr = '0;
					st_next.fbit = '0;
					st_next.fcrc = CRC_SEED;
					st_next.ecc = 1'b0;
				end
			end
			FS_READ: begin
				st_next.fcrc = fuse_crc_step; // R7
				st_next.fbit = st_reg.fbit + 3'h1;
				if (st_reg.fbit == BIT_LAST) begin
					st_next.fptr = st_reg.fptr + FP_W'(1);
					if (st_reg.fptr == FP_W'(FUSE_WORDS - 1)) begin
						if (synd == 8'h00) begin
							fuse_end = 1'b1;
						end else begin
							st_next.fs = FS_SEARCH;
							st_next.fsynd = synd;
							st_next.fwt = CRC_POLY;
							st_next.fcnt = '0;
						end
					end
				end
			end
			FS_SEARCH: begin
				if (st_reg.fwt == st_reg.fsynd) begin
					st_next.ecc = 1'b1; // R9
					fuse_end = 1'b1;
				end else if (st_reg.fcnt == FC_W'(FUSE_WORDS * 8 - 1)) begin
					err_set[ERR_FUSE] = 1'b1; // R9
					fuse_end = 1'b1;
				end else begin
					st_next.fwt = fuse_wt_step;
					st_next.fcnt = st_reg.fcnt + FC_W'(1);
				end
			end
			default: begin
				fuse_end = 1'b1;
			end
		endcase
		if (fuse_end) begin
			st_next.fs = FS_IDLE;
			st_next.diag[DIAG_FUSE_GO] = 1'b0; // R8
		end
		st_next.suspend = (st_next.fs != FS_IDLE); // R8
		// Clock activity counter.
		if (st_reg.diag[DIAG_MCLK_EN]) begin
			if (st_reg.mdiv == MD_W'(MCLK_DIV - 1)) begin
				st_next.mdiv = '0;
				st_next.mcnt = st_reg.mcnt + MCLK_CNT_W'(1); // R11
			end else begin
				st_next.mdiv = st_reg.mdiv + MD_W'(1);
			end
		end else begin
			st_next.mdiv = '0;
		end
		// Sticky flags: a new event wins over its read-clear.
		st_next.err = (st_reg.err & ~err_clr) | err_set; // R22
		st_next.ovr = (st_reg.ovr & ~ovr_clr) |
			(st_reg.diag[DIAG_OVR_EN] ? overrange_event : '0); // R10
		st_next.no_err = ~|{st_next.err, st_next.ovr}; // R6
		st_next.dout_en = ~st_next.src_sel; // R3
		// Snapshot read by the serial side while a frame runs.
		if (cs_fall || st_reg.done_d) begin
			st_next.snap_err = st_reg.err;
			st_next.snap_ovr = st_reg.ovr;
			st_next.snap_ecc = st_reg.ecc;
			st_next.snap_noerr = st_reg.no_err;
			st_next.snap_mcnt = st_reg.mcnt;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs come straight from the state registers.
	assign sdo = lk_reg.sdo;
	assign first_conversion_output = lk_reg.dout;
	assign first_conversion_output_enable = st_reg.dout_en;
	assign output_suspend = st_reg.suspend;
	assign fuse_addr = st_reg.fptr;
	assign overrange_flags = st_reg.ovr;
	assign error_flags = st_reg.err;
	assign no_chip_error = st_reg.no_err;
	assign fuse_ecc_status = st_reg.ecc;
	assign master_clock_counter = st_reg.mcnt;
	assign minimum_io_mode = st_reg.min_io;

	////////////////////////////////////////////////////////////////////////
	// Checks on the master clock side.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_min_io_exit;
		cs_rise && st_reg.min_io |=> !minimum_io_mode ##1 !minimum_io_mode;
	endproperty
	a_min_io_exit: assert property (p_min_io_exit) // R1
		else $error("minimum I/O mode not left on select toggle");

	property p_min_io_once;
		!minimum_io_mode |=> !minimum_io_mode;
	endproperty
	a_min_io_once: assert property (p_min_io_once) // R1
		else $error("minimum I/O mode re-entered");

	property p_master_bit;
		(|error_flags || |overrange_flags) != no_chip_error;
	endproperty
	a_master_bit: assert property (p_master_bit) // R6
		else $error("master no-error bit disagrees with flags");

	property p_flag_sticky;
		!done |=> (error_flags & $past(error_flags)) == $past(error_flags);
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) // R5
		else $error("error flag dropped without a read");

	property p_event_kept;
		st_reg.diag[DIAG_OVR_EN] && |overrange_event |=>
			(overrange_flags & $past(overrange_event)) ==
			$past(overrange_event);
	endproperty
	a_event_kept: assert property (p_event_kept) // R22
		else $error("overrange event lost");

	property p_trigger_suspends;
		st_reg.fs == FS_IDLE && st_reg.diag[DIAG_FUSE_GO] |=>
			output_suspend throughout (##1 1'b1);
	endproperty
	a_trigger_suspends: assert property (p_trigger_suspends) // R8
		else $error("fuse check started without suspending data");

	property p_trigger_clears;
		$fell(output_suspend) |-> !st_reg.diag[DIAG_FUSE_GO];
	endproperty
	a_trigger_clears: assert property (p_trigger_clears) // R8
		else $error("fuse trigger not cleared at check end");

	property p_fuse_uncorrectable;
		st_reg.fs == FS_SEARCH && st_reg.fwt != st_reg.fsynd &&
			st_reg.fcnt == FC_W'(FUSE_WORDS * 8 - 1) |=>
			error_flags[ERR_FUSE] && !output_suspend;
	endproperty
	a_fuse_uncorrectable: assert property (p_fuse_uncorrectable) // R9
		else $error("uncorrectable fuse error not flagged");

	property p_counter_tick;
		st_reg.diag[DIAG_MCLK_EN] && st_reg.mdiv == MD_W'(MCLK_DIV - 1) |=>
			master_clock_counter == $past(master_clock_counter) +
			MCLK_CNT_W'(1);
	endproperty
	a_counter_tick: assert property (p_counter_tick) // R11
		else $error("clock counter missed its tick");

	property p_counter_hold;
		st_reg.mdiv != MD_W'(MCLK_DIV - 1) |=> $stable(master_clock_counter);
	endproperty
	a_counter_hold: assert property (p_counter_hold) // R11
		else $error("clock counter moved between ticks");

	property p_undef_write;
		done && !f_rd && !scd_writable(f_addr) |=>
			error_flags[ERR_WR] && $stable(st_reg.diag[7:1]);
	endproperty
	a_undef_write: assert property (p_undef_write) // R12
		else $error("undefined write not flagged or not ignored");

	// Reply zeros on the serial side between status and data.
	property p_reply_zeros;
		@(posedge sclk) disable iff (frame_rst)
		!lk_reg.sel_sync && pos_reg >= 5'h02 && pos_reg <= POS_DATA
			|-> !sdo;
	endproperty
	a_reply_zeros: assert property (p_reply_zeros) // R19
		else $error("reply padding bit not zero");

	c_min_io_exit: cover property (cs_rise && st_reg.min_io);
	c_fuse_fixed: cover property ($rose(fuse_ecc_status));
	c_crc_fail: cover property ($rose(error_flags[ERR_CRC]));
	c_read_clear: cover property (done && f_rd && f_addr == ADDR_ERR_STAT);

endmodule // scd_monitor

// [sim/scd_host.sv]
// Host serial master model that frames and clocks register accesses.
`timescale 1ns/1ps
module scd_host (
	output logic      sclk, // Serial clock, still between frames.
	output logic      cs_n, // Chip select, low.
	output logic      sdi,  // Data to the device.
	input  wire logic sdo   // Reply from the device.
);
	// Boot wiring: select tied low, clock idle.
	initial begin
		sclk = 1'b0;
		cs_n = 1'b0;
		sdi = 1'b0;
	end

	// Sends n bits of w first bit first, samples replies on falling edges.
	task automatic xfer(input logic [23:0] w, input int n,
		output logic [23:0] r);
		cs_n = 1'b1;
		#207 cs_n = 1'b0;
		#200 r = '0;
		for (int i = 0; i < n; i++) begin
			sdi = w[23-i];
			#32 sclk = 1'b1;
			#32 sclk = 1'b0;
			r = {r[22:0], sdo};
		end
		sdi = ~sdi;
		#100 cs_n = 1'b1;
		#300;
	endtask
endmodule // scd_host

// [sim/scd_monitor_tb.sv]
// Self-checking bench for the SPI diagnostics monitor.
`timescale 1ns/1ps
module scd_monitor_tb;
	import scd_pkg::*;
	logic        clk, rst, sclk, cs_n, sdi, conv_data, sdo, fcoe, susp;
	logic        nce, ecc, mio, fco;
	logic [0:0]  fuse_addr;
	logic [7:0]  fuse_data, fuse_crc, cnt, c0;
	logic [7:0]  fuse_mem [2];
	logic [3:0]  ovr_ev, ovr;
	logic [4:0]  err;
	logic [23:0] r;
	int          err_count, num_checks, cyc, ch;

	scd_monitor #(.MCLK_DIV(8), .FUSE_WORDS(2)) scd_monitor_i (.clk, .rst,
		.sclk, .cs_n, .sdi, .conv_data, .sdo, .first_conversion_output(fco),
		.first_conversion_output_enable(fcoe), .output_suspend(susp),
		.fuse_addr, .fuse_data, .fuse_stored_crc(fuse_crc),
		.overrange_event(ovr_ev), .overrange_flags(ovr), .error_flags(err),
		.no_chip_error(nce), .fuse_ecc_status(ecc),
		.master_clock_counter(cnt), .minimum_io_mode(mio));
	scd_host scd_host_i (.sclk, .cs_n, .sdi, .sdo);
	assign fuse_data = fuse_mem[fuse_addr];

	// Checksum reference: x8+x2+x+1, seed a5, first bit first.
	function automatic logic [7:0] crc8(input logic [15:0] m);
		logic [7:0] c;
		c = 8'ha5;
		for (int i = 15; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction

	// Expected fuse check result {corrected, failed} for the fuse bytes.
	function automatic logic [1:0] fuse_exp();
		logic [15:0] m;
		m = {fuse_mem[0], fuse_mem[1]};
		if (crc8(m) == fuse_crc)
			return 2'b00;
		for (int i = 0; i < 16; i++)
			if (crc8(m ^ (16'h1 << i)) == fuse_crc)
				return 2'b10;
		return 2'b01;
	endfunction

	// Counts a comparison and reports a mismatch.
	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("BAD %0t %s", $time, m);
		end
	endtask

	// Full frame with a good or a spoiled host checksum.
	task automatic acc(input logic [7:0] cmd, input logic [7:0] d,
		input logic bad);
		scd_host_i.xfer({cmd, d, crc8({cmd, d}) ^ {7'h0, bad}}, 24, r);
		@(negedge clk);
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Master clock, 40 ns.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Hang guard and random data path bits.
	always @(negedge clk) begin
		conv_data <= 1'($urandom);
		if (++cyc > 20000) begin
			err_count++;
			finish_test();
		end
	end

	// Main sequence.
	initial begin
		void'($urandom(89));
		rst = 1'b1;
		ovr_ev = 4'h0;
		fuse_mem[0] = 8'($urandom);
		fuse_mem[1] = 8'($urandom);
		fuse_crc = crc8({fuse_mem[0], fuse_mem[1]});
		repeat (12) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk(mio === 1'b1 && susp === 1'b1, "boot state");
		repeat (100) @(negedge clk);
		chk(err === 5'h00 && nce === 1'b1 && ecc === 1'b0, "fuse");
		$display("boot test done");
		acc(8'h25, 8'h2c, 1'b0);
		chk(mio === 1'b0, "mode exit");
		chk(r === {16'h0, crc8(16'h252c)}, "write reply");
		acc(8'ha5, 8'h2c, 1'b0);
		chk(r === {8'h0, 8'h2c, crc8(16'ha52c)}, "read reply");
		acc(8'h7f, 8'h11, 1'b0);
		chk(err === 5'h04 && nce === 1'b0, "bad address");
		acc(8'hc0, 8'h04, 1'b0);
		chk(r[23:8] === 16'h8004, "status");
		chk(err === 5'h00 && nce === 1'b1, "read clear");
		acc(8'hff, 8'h00, 1'b0);
		chk(err === 5'h02 && nce === 1'b0, "bad read");
		$display("register test done");
		acc(8'h25, 8'h00, 1'b1);
		chk(err[4] === 1'b1, "crc flag");
		acc(8'ha5, 8'h2c, 1'b0);
		chk(r[23:8] === 16'h802c, "write refused");
		scd_host_i.xfer(24'h0, 12, r);
		@(negedge clk);
		chk(err[3] === 1'b1, "clock count");
		$display("error test done");
		ch = $urandom_range(3);
		ovr_ev = 4'h1 << ch;
		@(negedge clk);
		ovr_ev = 4'h0;
		chk(ovr === 4'h1 << ch, "overrange");
		c0 = cnt;
		repeat (80) @(negedge clk);
		chk(cnt === 8'(c0 + 8'd10), "counter");
		c0 = 8'h1 << ch;
		acc(8'hc1, c0, 1'b0);
		chk(r[15:8] === c0 && ovr === 4'h0, "overrange clear");
		acc(8'h10, 8'h04, 1'b0);
		chk(fcoe === 1'b0, "source select");
		acc(8'h25, 8'h2d, 1'b0);
		chk(susp === 1'b1 && sdo === fco, "check runs");
		repeat (100) @(negedge clk);
		chk(susp === 1'b0 && err[0] === 1'b0, "check ends");
		// Flip one fuse bit, then another, and rerun the check each time.
		repeat (2) begin
			ch = $urandom_range(15);
			fuse_mem[ch[3]] = fuse_mem[ch[3]] ^ (8'h1 << ch[2:0]);
			acc(8'h25, 8'h2d, 1'b0);
			repeat (100) @(negedge clk);
			chk({ecc, err[0]} === fuse_exp(), "fuse fix");
		end
		$display("monitor test done");
		finish_test();
	end
endmodule // scd_monitor_tb
